//--- hdl/sdram_state_pkg.sv
// Package with command codes, bank states, timing constants and carrier structs.
package sdram_state_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 66;
	localparam int MODE_REGISTER_DELAY_NS = 15;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 67;
	localparam int ROW_ACTIVE_TIME_NS = 44;
	localparam int REFRESH_INTERVAL_NS = 7813;
	localparam int SELF_REFRESH_EXIT_MIN_CYC = 2;
	localparam int BURST_LEN_CYC = 4;
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	function automatic int cyc_down(input int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int PRECHARGE_TIME_CYC = cyc_up(PRECHARGE_TIME_NS);
	localparam int ACTIVATE_TO_ACCESS_DELAY_CYC = cyc_up(ACTIVATE_TO_ACCESS_DELAY_NS);
	localparam int REFRESH_CYCLE_TIME_CYC = cyc_up(REFRESH_CYCLE_TIME_NS);
	localparam int MODE_REGISTER_DELAY_CYC = cyc_up(MODE_REGISTER_DELAY_NS);
	localparam int SR_EXIT_RAW_CYC = cyc_up(SELF_REFRESH_EXIT_TIME_NS);
	localparam int SELF_REFRESH_EXIT_TIME_CYC =
		(SR_EXIT_RAW_CYC < SELF_REFRESH_EXIT_MIN_CYC) ? SELF_REFRESH_EXIT_MIN_CYC : SR_EXIT_RAW_CYC;
	localparam int ROW_ACTIVE_TIME_CYC = cyc_up(ROW_ACTIVE_TIME_NS);
	localparam int REFRESH_INTERVAL_CYC = cyc_down(REFRESH_INTERVAL_NS);
	localparam int NUM_BANKS = 4;
	localparam int ROW_BITS = 13;
	localparam int TIMER_BITS = 8;
	localparam int ADDR_BIT_TEN = 10;
	localparam logic [ROW_BITS-1:0] ROW_RESET = 13'h0000;
	localparam logic [TIMER_BITS-1:0] TIMER_ZERO = 8'h00;
	localparam logic [TIMER_BITS-1:0] TIMER_ONE = 8'h01;
	// Command codes are {row strobe, column strobe, write enable}, chip select low.
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_BURST_STOP = 3'h6;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
	typedef enum logic [3:0] {
		BANK_IDLE = 4'h0,
		BANK_ACTIVATING = 4'h1,
		BANK_ROW_ACTIVE = 4'h2,
		BANK_READ = 4'h3,
		BANK_WRITE = 4'h4,
		BANK_READ_AP = 4'h5,
		BANK_WRITE_AP = 4'h6,
		BANK_PRECHARGING = 4'h7
	} bank_state_t;
	typedef enum logic [2:0] {
		DEV_NORMAL = 3'h0,
		DEV_REFRESHING = 3'h1,
		DEV_MODE_ACCESS = 3'h2,
		DEV_PRECHARGE_ALL = 3'h3,
		DEV_SELF_REFRESH = 3'h4,
		DEV_SR_EXIT = 3'h5
	} dev_state_t;
	typedef struct packed {
		logic cs_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic we_n;
		logic bank_select_high;
		logic bank_select_low;
		logic [ROW_BITS-1:0] addr;
	} cmd_bus_t;
	typedef struct packed {
		logic valid;
		logic [ROW_BITS-1:0] row;
	} refresh_evt_t;
endpackage

//--- hdl/sdram_refresh_bank_state.sv
// Refresh control and per-bank command acceptance state of a four-bank synchronous DRAM.
`timescale 1ns/1ps
`default_nettype none
module sdram_refresh_bank_state
	import sdram_state_pkg::*;
#(
	parameter bit AUTOMOTIVE = 1'b0
)
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic cke_i,
	input wire cmd_bus_t cmd_i,
	output bank_state_t bank_state_o [NUM_BANKS],
	output dev_state_t dev_state_o,
	output refresh_evt_t refresh_o,
	output logic illegal_cmd_o,
	output logic unsupported_o,
	output logic [1:0] last_burst_bank_o
);
	bank_state_t bank_q [NUM_BANKS];
	bank_state_t bank_d [NUM_BANKS];
	logic [TIMER_BITS-1:0] btimer_q [NUM_BANKS];
	logic [TIMER_BITS-1:0] btimer_d [NUM_BANKS];
	logic [NUM_BANKS-1:0] bank_bad;
	dev_state_t dev_q, dev_d;
	logic [TIMER_BITS-1:0] dtimer_q, dtimer_d;
	logic [15:0] sr_timer_q, sr_timer_d;
	logic [ROW_BITS-1:0] row_q;
	logic [1:0] last_q;
	logic [1:0] burst_cnt_q [NUM_BANKS];
	logic illegal_q, unsup_q;
	refresh_evt_t refresh_q;
	localparam int ACT_DELAY_CYC = ACTIVATE_TO_ACCESS_DELAY_CYC;

	wire [2:0] code = {cmd_i.row_strobe_n, cmd_i.col_strobe_n, cmd_i.we_n};
	wire [1:0] sel_bank = {cmd_i.bank_select_high, cmd_i.bank_select_low};
	wire cmd_live = !cmd_i.cs_n && code != CMD_NOP;
	wire ap_bit = cmd_i.addr[ADDR_BIT_TEN];
	wire in_normal = dev_q == DEV_NORMAL;
	wire is_act = cmd_live && code == CMD_ACTIVATE;
	wire is_rd = cmd_live && code == CMD_READ;
	wire is_wr = cmd_live && code == CMD_WRITE;
	wire is_pre = cmd_live && code == CMD_PRECHARGE;
	wire is_ref = cmd_live && code == CMD_REFRESH;
	wire is_mrs = cmd_live && code == CMD_MODE_LOAD;
	wire is_stop = cmd_live && code == CMD_BURST_STOP;
	wire pre_all = is_pre && ap_bit;
	logic all_idle;
	always_comb
	begin
		all_idle = 1'b1;
		for (int b = 0; b < NUM_BANKS; b++)
			if (bank_q[b] != BANK_IDLE)
				all_idle = 1'b0;
	end
	wire ref_ok = in_normal && is_ref && all_idle && cke_i;
	wire sr_req = in_normal && is_ref && all_idle && !cke_i;
	wire sr_ok = sr_req && !AUTOMOTIVE;
	wire mrs_ok = in_normal && is_mrs && all_idle && cke_i;
	wire dev_bad = in_normal && (is_ref || is_mrs) && !all_idle;
	wire busy_bad = !in_normal && dev_q != DEV_SELF_REFRESH && cmd_live;
	wire sr_tick = sr_timer_q == 16'h0000;
	wire refresh_now = ref_ok || (dev_q == DEV_SELF_REFRESH && sr_tick);

	// Per-bank next state; a bank reacts to commands it is named by, to precharge all, and to burst stop when it holds the latest burst.
	always_comb
	begin
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			logic hit;
			logic tmo;
			hit = (sel_bank == 2'(b)) && in_normal && cke_i;
			tmo = btimer_q[b] == TIMER_ONE;
			bank_d[b] = bank_q[b];
			btimer_d[b] = (btimer_q[b] == TIMER_ZERO) ? TIMER_ZERO : btimer_q[b] - TIMER_ONE;
			bank_bad[b] = 1'b0;
			case (bank_q[b])
				BANK_IDLE:
				begin
					if (hit && is_act)
					begin
						bank_d[b] = BANK_ACTIVATING;
						btimer_d[b] = TIMER_BITS'(ACTIVATE_TO_ACCESS_DELAY_CYC);
					end
					// Burst stop is not bank-specific, so an idle bank named by it is no fault.
					else if (hit && (is_rd || is_wr))
						bank_bad[b] = 1'b1;
				end
				BANK_ACTIVATING, BANK_PRECHARGING:
				begin
					if (tmo)
						bank_d[b] = (bank_q[b] == BANK_ACTIVATING) ? BANK_ROW_ACTIVE : BANK_IDLE;
					if (hit && (is_act || is_rd || is_wr || (is_pre && !ap_bit)))
						bank_bad[b] = 1'b1;
				end
				BANK_READ_AP, BANK_WRITE_AP:
				begin
					if (tmo)
						bank_d[b] = BANK_IDLE;
					if (hit && (is_act || is_rd || is_wr || (is_pre && !ap_bit)))
						bank_bad[b] = 1'b1;
				end
				default:
				begin
					// Row active, read and write bursts share the same acceptance set.
					if (hit && is_rd)
						bank_d[b] = ap_bit ? BANK_READ_AP : BANK_READ;
					else if (hit && is_wr)
						bank_d[b] = ap_bit ? BANK_WRITE_AP : BANK_WRITE;
					else if (hit && is_act)
						bank_bad[b] = 1'b1;
					else if (bank_q[b] != BANK_ROW_ACTIVE && burst_cnt_q[b] == 2'h0)
						bank_d[b] = BANK_ROW_ACTIVE;
					if (hit && (is_rd || is_wr) && ap_bit)
						btimer_d[b] = TIMER_BITS'(BURST_LEN_CYC + PRECHARGE_TIME_CYC);
					if (is_stop && last_q == 2'(b) && bank_q[b] != BANK_ROW_ACTIVE)
						bank_d[b] = BANK_ROW_ACTIVE;
				end
			endcase
			if (in_normal && cke_i && is_pre && (pre_all || sel_bank == 2'(b)) && !bank_bad[b]
				&& bank_q[b] != BANK_IDLE && bank_q[b] != BANK_ACTIVATING
				&& bank_q[b] != BANK_READ_AP && bank_q[b] != BANK_WRITE_AP
				&& bank_q[b] != BANK_PRECHARGING)
			begin
				bank_d[b] = BANK_PRECHARGING;
				btimer_d[b] = TIMER_BITS'(PRECHARGE_TIME_CYC);
			end
		end
	end

	// Device-wide modes: refresh, mode access, precharge-all, self refresh.
	always_comb
	begin
		dev_d = dev_q;
		dtimer_d = (dtimer_q == TIMER_ZERO) ? TIMER_ZERO : dtimer_q - TIMER_ONE;
		sr_timer_d = sr_timer_q;
		case (dev_q)
			DEV_NORMAL:
			begin
				if (ref_ok)
				begin
					dev_d = DEV_REFRESHING;
					dtimer_d = TIMER_BITS'(REFRESH_CYCLE_TIME_CYC);
				end
				else if (sr_ok)
				begin
					dev_d = DEV_SELF_REFRESH;
					sr_timer_d = 16'(REFRESH_INTERVAL_CYC);
				end
				else if (mrs_ok)
				begin
					dev_d = DEV_MODE_ACCESS;
					dtimer_d = TIMER_BITS'(MODE_REGISTER_DELAY_CYC);
				end
				else if (pre_all && cke_i)
				begin
					dev_d = DEV_PRECHARGE_ALL;
					dtimer_d = TIMER_BITS'(PRECHARGE_TIME_CYC);
				end
			end
			DEV_REFRESHING, DEV_MODE_ACCESS, DEV_PRECHARGE_ALL, DEV_SR_EXIT:
			begin
				if (dtimer_q == TIMER_ONE)
					dev_d = DEV_NORMAL;
			end
			DEV_SELF_REFRESH:
			begin
				// Only clock enable is looked at here; the command pins are ignored.
				sr_timer_d = sr_tick ? 16'(REFRESH_INTERVAL_CYC) : sr_timer_q - 16'h0001;
				if (cke_i)
				begin
					dev_d = DEV_SR_EXIT;
					dtimer_d = TIMER_BITS'(SELF_REFRESH_EXIT_TIME_CYC);
				end
			end
			default:
				dev_d = DEV_NORMAL;
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			for (int b = 0; b < NUM_BANKS; b++)
			begin
				bank_q[b] <= BANK_IDLE;
				btimer_q[b] <= TIMER_ZERO;
			end
		end
		else
		begin
			bank_q <= bank_d;
			btimer_q <= btimer_d;
		end
	end

	// Burst length counters per bank; a new read or write restarts the count.
	always_ff @(posedge clk_sys_i)
	begin
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			if (!rst_n_i)
				burst_cnt_q[b] <= 2'h0;
			else if (in_normal && cke_i && (is_rd || is_wr) && sel_bank == 2'(b) && !bank_bad[b])
				burst_cnt_q[b] <= 2'(BURST_LEN_CYC - 1);
			else if (burst_cnt_q[b] != 2'h0)
				burst_cnt_q[b] <= burst_cnt_q[b] - 2'h1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			dev_q <= DEV_NORMAL;
			dtimer_q <= TIMER_ZERO;
			sr_timer_q <= 16'h0000;
			row_q <= ROW_RESET;
			last_q <= 2'h0;
			illegal_q <= 1'b0;
			unsup_q <= 1'b0;
			refresh_q <= '0;
		end
		else
		begin
			dev_q <= dev_d;
			dtimer_q <= dtimer_d;
			sr_timer_q <= sr_timer_d;
			if (refresh_now)
				row_q <= row_q + 13'h0001;
			refresh_q.valid <= refresh_now;
			refresh_q.row <= row_q;
			if (in_normal && cke_i && (is_rd || is_wr) && !bank_bad[sel_bank])
				last_q <= sel_bank;
			illegal_q <= (|bank_bad) || dev_bad || busy_bad;
			unsup_q <= sr_req && AUTOMOTIVE;
		end
	end

	assign bank_state_o = bank_q;
	assign dev_state_o = dev_q;
	assign refresh_o = refresh_q;
	assign illegal_cmd_o = illegal_q;
	assign unsupported_o = unsup_q;
	assign last_burst_bank_o = last_q;

	sequence s_ref_taken;
		ref_ok;
	endsequence
	a_refresh_row_count: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		s_ref_taken |=> refresh_o.valid && row_q == $past(row_q) + 13'h0001)
		else $error("Refresh did not advance the internal row counter.");
	a_refresh_needs_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(in_normal && is_ref && !all_idle) |=> illegal_cmd_o && dev_q == DEV_NORMAL)
		else $error("Refresh with open bank was not refused.");
	a_self_ref_entry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sr_req && !AUTOMOTIVE) |=> dev_q == DEV_SELF_REFRESH)
		else $error("Self refresh not entered.");
	a_self_ref_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(dev_q == DEV_SELF_REFRESH && !cke_i) |=> dev_q == DEV_SELF_REFRESH && !illegal_cmd_o)
		else $error("Self refresh left or flagged while clock enable low.");
	a_self_ref_tick: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(dev_q == DEV_SELF_REFRESH && sr_tick) |=> refresh_o.valid)
		else $error("Internal self refresh tick missed.");
	a_exit_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(dev_q == DEV_SELF_REFRESH && cke_i) |=> dev_q == DEV_SR_EXIT [*2])
		else $error("Self refresh exit shorter than two clocks.");
	a_auto_unsup: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(sr_req && AUTOMOTIVE) |=> unsupported_o && dev_q == DEV_NORMAL)
		else $error("Automotive self refresh not refused.");
	a_inhibit_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cmd_i.cs_n && bank_q[0] == BANK_ROW_ACTIVE && burst_cnt_q[0] == 2'h0) |=> bank_q[0] == BANK_ROW_ACTIVE)
		else $error("Inhibit changed an active bank.");
	a_activate_time: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bank_q[0] == BANK_IDLE && sel_bank == 2'h0 && is_act && in_normal && cke_i)
		|=> bank_q[0] == BANK_ACTIVATING ##ACT_DELAY_CYC bank_q[0] == BANK_ROW_ACTIVE)
		else $error("Activate timing wrong.");
	a_precharge_all: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(pre_all && in_normal && cke_i && bank_q[1] == BANK_ROW_ACTIVE) |=> bank_q[1] == BANK_PRECHARGING)
		else $error("Precharge all missed a bank.");
	a_burst_stop_latest: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(is_stop && in_normal && bank_q[last_q] == BANK_READ) |=> bank_q[$past(last_q)] == BANK_ROW_ACTIVE)
		else $error("Burst stop did not end latest burst.");
endmodule
`default_nettype wire

//--- verif/ctrl_model.sv
// Behavioural memory controller that drives the command pins of the refresh and bank block.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
	import sdram_state_pkg::*;
(
	input wire logic clk_sys_i,
	output logic cke_o,
	output cmd_bus_t cmd_o
);
	initial
	begin
		cke_o = 1'b1;
		cmd_o = {1'b0, CMD_NOP, 2'h0, 13'h0000};
	end

	// One command, then no-operations; clock enable stays where the caller put it.
	task issue(input logic cs_n, input logic [2:0] c, input logic [1:0] bk, input logic [12:0] a, input logic k);
		@(posedge clk_sys_i);
		#1;
		cke_o = k;
		cmd_o = {cs_n, c, bk, a};
		@(posedge clk_sys_i);
		#1;
		// Don't-care pins are inverted so a stale value can never look like a real one.
		cmd_o = {1'b0, CMD_NOP, ~bk, ~a};
	endtask

	task nops(input int n);
		repeat (n)
		begin
			@(posedge clk_sys_i);
			#1;
			cmd_o.addr = ~cmd_o.addr;
		end
	endtask

	// The clock never stops here, so it is always stable before clock enable rises.
	task wake();
		@(posedge clk_sys_i);
		#1;
		cke_o = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- verif/sdram_refresh_bank_state_tb.sv
// Self-checking testbench for the refresh and bank state block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s: expected %0h seen %0h", n, e, g); end end
module sdram_refresh_bank_state_tb
	import sdram_state_pkg::*;
;
	logic clk_sys_i;
	logic rst_n_i;
	logic cke;
	cmd_bus_t cmd;
	bank_state_t bs[NUM_BANKS];
	bank_state_t bs_a[NUM_BANKS];
	bank_state_t exp_bs[NUM_BANKS];
	dev_state_t dev;
	dev_state_t dev_a;
	refresh_evt_t rf;
	refresh_evt_t rf_a;
	logic ill;
	logic ill_a;
	logic uns;
	logic uns_a;
	logic [1:0] lbb;
	logic [1:0] lbb_a;
	logic [1:0] b;
	logic [12:0] exp_row;
	int error_cnt;
	int samples_checked;
	int seed;
	int n;
	logic [2:0] seq_c[6] = '{CMD_READ, CMD_WRITE, CMD_READ, CMD_BURST_STOP, CMD_WRITE, CMD_PRECHARGE};
	bank_state_t seq_s[6] = '{BANK_READ, BANK_WRITE, BANK_READ, BANK_ROW_ACTIVE, BANK_WRITE, BANK_PRECHARGING};

	ctrl_model ctrl_model_i (.clk_sys_i(clk_sys_i), .cke_o(cke), .cmd_o(cmd));
	sdram_refresh_bank_state sdram_refresh_bank_state_i (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .cke_i(cke), .cmd_i(cmd), .bank_state_o(bs), .dev_state_o(dev), .refresh_o(rf),
		.illegal_cmd_o(ill), .unsupported_o(uns), .last_burst_bank_o(lbb));
	sdram_refresh_bank_state #(.AUTOMOTIVE(1'b1)) sdram_refresh_bank_state_a_i (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .cke_i(cke), .cmd_i(cmd), .bank_state_o(bs_a), .dev_state_o(dev_a), .refresh_o(rf_a),
		.illegal_cmd_o(ill_a), .unsupported_o(uns_a), .last_burst_bank_o(lbb_a));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	task chk(input dev_state_t d, input logic il);
		for (int i = 0; i < NUM_BANKS; i++)
		begin
			`CHK("bank state", exp_bs[i], bs[i])
			`CHK("automotive bank state", exp_bs[i], bs_a[i])
		end
		`CHK("device state", d, dev)
		`CHK("illegal flag", il, ill)
	endtask

	task report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (3000) @(posedge clk_sys_i);
		error_cnt++;
		report_and_stop();
	end

	initial
	begin
		seed = 68;
		error_cnt = 0;
		samples_checked = 0;
		exp_row = 13'h0000;
		rst_n_i = 1'b0;
		foreach (exp_bs[i]) exp_bs[i] = BANK_IDLE;
		repeat (5) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		chk(DEV_NORMAL, 1'b0);
		`CHK("refresh valid", 1'b0, rf.valid)
		$display("test reset done");
		b = 2'($random(seed));
		ctrl_model_i.issue(1'b0, CMD_ACTIVATE, b, 13'($random(seed)), 1'b1);
		exp_bs[b] = BANK_ACTIVATING;
		chk(DEV_NORMAL, 1'b0);
		ctrl_model_i.nops(1);
		exp_bs[b] = BANK_ROW_ACTIVE;
		chk(DEV_NORMAL, 1'b0);
		for (int k = 0; k < 6; k++)
		begin
			// Burst stop goes to another bank: it must still hit the latest burst.
			ctrl_model_i.issue(1'b0, seq_c[k], (seq_c[k] == CMD_BURST_STOP) ? ~b : b,
				13'($random(seed)) & 13'h1bff, 1'b1);
			exp_bs[b] = seq_s[k];
			chk(DEV_NORMAL, 1'b0);
			`CHK("last burst bank", b, lbb)
			`CHK("automotive last burst bank", b, lbb_a)
		end
		ctrl_model_i.nops(1);
		exp_bs[b] = BANK_IDLE;
		chk(DEV_NORMAL, 1'b0);
		ctrl_model_i.issue(1'b0, CMD_PRECHARGE, b, 13'($random(seed)) & 13'h1bff, 1'b1);
		chk(DEV_NORMAL, 1'b0);
		ctrl_model_i.issue(1'b0, CMD_READ, b, 13'($random(seed)), 1'b1);
		chk(DEV_NORMAL, 1'b1);
		$display("test bank done");
		ctrl_model_i.issue(1'b0, CMD_ACTIVATE, 2'h0, 13'($random(seed)), 1'b1);
		ctrl_model_i.issue(1'b0, CMD_ACTIVATE, 2'h1, 13'($random(seed)), 1'b1);
		ctrl_model_i.nops(1);
		exp_bs[0] = BANK_ROW_ACTIVE;
		exp_bs[1] = BANK_ROW_ACTIVE;
		// Inhibits go out while rows are open, so a stray decode would show in the bank states.
		repeat (8)
		begin
			ctrl_model_i.issue(1'b1, 3'($random(seed)), 2'($random(seed)), 13'($random(seed)), 1'b1);
			chk(DEV_NORMAL, 1'b0);
		end
		$display("test inhibit done");
		ctrl_model_i.issue(1'b0, CMD_REFRESH, 2'($random(seed)), 13'($random(seed)), 1'b1);
		chk(DEV_NORMAL, 1'b1);
		`CHK("refresh valid", 1'b0, rf.valid)
		ctrl_model_i.issue(1'b0, CMD_PRECHARGE, 2'($random(seed)), 13'h0400, 1'b1);
		`CHK("device state", DEV_PRECHARGE_ALL, dev)
		ctrl_model_i.nops(1);
		exp_bs[0] = BANK_IDLE;
		exp_bs[1] = BANK_IDLE;
		chk(DEV_NORMAL, 1'b0);
		$display("test precharge all done");
		repeat (3)
		begin
			// Two clocks apart, one more than the refresh cycle time, address pins random.
			ctrl_model_i.issue(1'b0, CMD_REFRESH, 2'($random(seed)), 13'($random(seed)), 1'b1);
			chk(DEV_REFRESHING, 1'b0);
			`CHK("refresh valid", 1'b1, rf.valid)
			`CHK("refresh row", exp_row, rf.row)
			exp_row++;
		end
		$display("test refresh done");
		ctrl_model_i.issue(1'b0, CMD_REFRESH, 2'($random(seed)), 13'($random(seed)), 1'b0);
		chk(DEV_SELF_REFRESH, 1'b0);
		`CHK("unsupported flag", 1'b0, uns)
		`CHK("unsupported flag", 1'b1, uns_a)
		`CHK("device state", DEV_NORMAL, dev_a)
		`CHK("automotive refresh valid", 1'b0, rf_a.valid)
		`CHK("automotive illegal flag", 1'b0, ill_a)
		repeat (4)
		begin
			ctrl_model_i.issue(1'b0, 3'($random(seed)), 2'($random(seed)), 13'($random(seed)), 1'b0);
			chk(DEV_SELF_REFRESH, 1'b0);
		end
		n = 0;
		while (rf.valid !== 1'b1 && n < 100)
		begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		`CHK("refresh valid", 1'b1, rf.valid)
		`CHK("refresh row", exp_row, rf.row)
		exp_row++;
		ctrl_model_i.wake();
		n = 0;
		repeat (4)
		begin
			@(posedge clk_sys_i);
			#1;
			if (dev === DEV_SR_EXIT)
				n++;
		end
		`CHK("exit cycles", SELF_REFRESH_EXIT_TIME_CYC, n)
		chk(DEV_NORMAL, 1'b0);
		// Resuming well inside the refresh interval keeps the shared row counter on time.
		ctrl_model_i.issue(1'b0, CMD_REFRESH, 2'($random(seed)), 13'($random(seed)), 1'b1);
		chk(DEV_REFRESHING, 1'b0);
		`CHK("refresh row", exp_row, rf.row)
		$display("test self refresh done");
		report_and_stop();
	end
endmodule
`default_nettype wire
